// file: src/srt_pkg.sv
// shared constants and types for the startup-range trip logic
package srt_pkg;

   // ----------------------------------------------------------------
   // channel and value geometry
   // ----------------------------------------------------------------
   localparam int NUM_CHANNELS = 3;
   localparam int FLUX_WIDTH   = 16;
   localparam int PERIOD_WIDTH = 16;
   localparam int RATE_WIDTH   = 16;

   // ----------------------------------------------------------------
   // period measurement span, seconds, as printed
   // ----------------------------------------------------------------
   localparam int PERIOD_NEG_LIMIT_S = -100;
   localparam int PERIOD_POS_LIMIT_S = 10;

   // ----------------------------------------------------------------
   // response filter: qualification counts, in evaluation cycles
   // ----------------------------------------------------------------
   localparam int FILT_WIDTH      = 4;
   localparam logic [FILT_WIDTH-1:0] FILT_FAST_CYC = 4'h1;
   localparam logic [FILT_WIDTH-1:0] FILT_SLOW_CYC = 4'h8;
   localparam logic [FILT_WIDTH-1:0] FILT_RESET    = 4'h0;

   // ----------------------------------------------------------------
   // evaluation tick: time and derived cycles at 125 MHz
   // ----------------------------------------------------------------
   localparam int CLK_MHZ       = 125;
   localparam int EVAL_PERIOD_NS = 1000;
   localparam int EVAL_CYC      = (EVAL_PERIOD_NS * CLK_MHZ) / 1000;
   localparam int EVAL_CNT_W    = 8;
   localparam logic [EVAL_CNT_W-1:0] EVAL_CNT_RESET = 8'h00;

   // ----------------------------------------------------------------
   // plant mode selector
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SRT_MODE_SHUTDOWN = 2'h0,
      SRT_MODE_REFUEL   = 2'h1,
      SRT_MODE_STARTUP  = 2'h2,
      SRT_MODE_RUN      = 2'h3
   } srt_mode_type;

endpackage : srt_pkg

// file: src/srt_trip_logic.sv
// startup-range trip, block, permissive and inoperative logic, one division
// Function
// (RULE_01) suppress channel trips while selector in run
// (RULE_02) non-coincident: any one channel trips
// (RULE_03) run forces coincident trip mode
// (RULE_04) alarm: run with non-coincident selector set
// (RULE_05) combine three scram trips into divisional trip
// (RULE_06) period trip active in both modes
// (RULE_07) inoperative: not operate, interlock, self-test, voltage
// (RULE_08) alarm when a channel is out of service
// (RULE_09) short-period warning inhibits continuous rod withdrawal
// (RULE_10) boron injection permissive to poison logic
// (RULE_11) magnitude thresholds are programmable inputs
// (RULE_12) response slower at low count rate
// (RULE_13) per-channel bypass removes trip contribution
// (RULE_14) scram on high flux or short period
// (RULE_15) rod block on flux high, low, failure
// (RULE_16) rod block when period below preset
// (RULE_17) works with one channel bypassed
// (RULE_18) period span minus 100 to plus 10 s
// (RULE_19) inputs sampled, outputs registered per evaluation
`timescale 1ns/1ps
`default_nettype none

module srt_trip_logic
   import srt_pkg::*;
#(
   parameter int N  = srt_pkg::NUM_CHANNELS,
   parameter int FW = srt_pkg::FLUX_WIDTH,
   parameter int PW = srt_pkg::PERIOD_WIDTH,
   parameter int RW = srt_pkg::RATE_WIDTH
) (
   // clock and reset
   input  wire logic                ref_clk,
   input  wire logic                srst,
   // plant mode and coincidence selectors (from panel switches)
   input  wire logic [1:0]          mode_sel,
   input  wire logic [N-1:0]        noncoinc_sel,
   // per-channel measurements (from channel processing, same clock)
   input  wire logic [N*FW-1:0]     flux,
   input  wire logic [N*PW-1:0]     period_s,
   input  wire logic [N*RW-1:0]     count_rate,
   // programmable setpoints
   input  wire logic [FW-1:0]       flux_hi_trip,
   input  wire logic [FW-1:0]       flux_hi_block,
   input  wire logic [FW-1:0]       flux_lo_block,
   input  wire logic [PW-1:0]       period_trip,
   input  wire logic [PW-1:0]       period_block,
   input  wire logic [PW-1:0]       period_warn,
   input  wire logic [FW-1:0]       boron_flux_level,
   input  wire logic [RW-1:0]       low_rate_level,
   // channel health (panel switches and monitors)
   input  wire logic [N-1:0]        chan_operate,
   input  wire logic [N-1:0]        interlock_closed,
   input  wire logic [N-1:0]        selftest_fail,
   input  wire logic [N-1:0]        excite_low,
   input  wire logic [N-1:0]        elec_fail,
   input  wire logic [N-1:0]        chan_bypass,
   // outputs to protection logic and interlocks
   output logic                     div_scram_trip,
   output logic [N-1:0]             chan_scram_trip,
   output logic                     rod_block,
   output logic                     withdraw_permissive,
   output logic                     boron_injection_permissive,
   output logic                     inop_alarm,
   output logic [N-1:0]             chan_inop,
   output logic                     coinc_alarm
);

   // ----------------------------------------------------------------
   // evaluation tick
   // ----------------------------------------------------------------
   localparam logic [EVAL_CNT_W-1:0] EVAL_LAST = EVAL_CNT_W'(EVAL_CYC - 1);

   logic [EVAL_CNT_W-1:0] eval_cnt_reg;
   logic [EVAL_CNT_W-1:0] eval_cnt_next;
   logic                  eval_tick;

   // one-cycle enable per evaluation
   assign eval_tick     = (eval_cnt_reg == EVAL_LAST);
   assign eval_cnt_next = eval_tick ? EVAL_CNT_RESET
                                    : eval_cnt_reg + 8'h01;

   always_ff @(posedge ref_clk) begin
      if (srst) eval_cnt_reg <= EVAL_CNT_RESET;
      else      eval_cnt_reg <= eval_cnt_next;
   end

   // ----------------------------------------------------------------
   // input synchronisers for panel-switch inputs
   // ----------------------------------------------------------------
   localparam int SW = 2 + 6 * N;

   logic [SW-1:0] sw_meta_reg;
   logic [SW-1:0] sw_sync_reg;

   // two stages; first stage is read only by the second
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         sw_meta_reg <= '0;
         sw_sync_reg <= '0;
      end else begin
         sw_meta_reg <= {mode_sel, noncoinc_sel, chan_operate,
                         interlock_closed, selftest_fail, excite_low,
                         chan_bypass}; // RULE_19
         sw_sync_reg <= sw_meta_reg;
      end
   end

   logic [1:0]   mode_s;
   logic [N-1:0] noncoinc_s;
   logic [N-1:0] operate_s;
   logic [N-1:0] ilock_s;
   logic [N-1:0] stfail_s;
   logic [N-1:0] exlow_s;
   logic [N-1:0] bypass_s;

   assign {mode_s, noncoinc_s, operate_s, ilock_s, stfail_s, exlow_s,
           bypass_s} = sw_sync_reg;

   // ----------------------------------------------------------------
   // mode decode
   // ----------------------------------------------------------------
   wire logic run_mode   = (mode_s == SRT_MODE_RUN);
   // run forces coincident mode whatever the selectors say
   wire logic noncoinc   = (|noncoinc_s) && !run_mode; // RULE_02 RULE_03
   wire logic coinc_warn = run_mode && (|noncoinc_s); // RULE_04

   // period compare: positive period shorter than a setpoint.
   // negative or infinite (zero code) periods never compare short.
   function automatic logic short_period(input logic [PW-1:0] p,
                                         input logic [PW-1:0] lim);
      logic pos;
      pos = !p[PW-1] && (p != '0);
      return pos && (p < lim); // RULE_18
   endfunction : short_period

   // ----------------------------------------------------------------
   // per-channel evaluation
   // ----------------------------------------------------------------
   logic [N-1:0] raw_trip;
   logic [N-1:0] raw_block;
   logic [N-1:0] raw_warn;
   logic [N-1:0] inop_w;
   logic [N-1:0] qual_trip;
   logic [N-1:0] qual_block;
   logic [N-1:0] boron_w;
   logic [N-1:0] active_w;

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_chan
         wire logic [FW-1:0] fx = flux[g*FW +: FW];
         wire logic [PW-1:0] pd = period_s[g*PW +: PW];
         wire logic [RW-1:0] cr = count_rate[g*RW +: RW];

         logic [FILT_WIDTH-1:0] trip_cnt_reg;
         logic [FILT_WIDTH-1:0] block_cnt_reg;

         // channel out of service
         assign inop_w[g] = !operate_s[g] || !ilock_s[g] ||
                            stfail_s[g] || exlow_s[g]; // RULE_07
         // scram on high flux or short period, in either mode
         assign raw_trip[g] = (fx > flux_hi_trip) ||
                              short_period(pd, period_trip) ||
                              inop_w[g]; // RULE_06 RULE_11 RULE_14
         assign raw_block[g] = (fx > flux_hi_block) ||
                               (fx < flux_lo_block) ||
                               elec_fail[g] || inop_w[g] || // RULE_15
                               short_period(pd, period_block); // RULE_16
         assign raw_warn[g] = short_period(pd, period_warn); // RULE_09
         assign boron_w[g]  = (fx < boron_flux_level) && !inop_w[g];
         // bypassed channels drop out of every vote
         assign active_w[g] = !bypass_s[g]; // RULE_13

         // low count rate waits longer before a trip or block stands
         wire logic [FILT_WIDTH-1:0] need =
            (cr < low_rate_level) ? FILT_SLOW_CYC : FILT_FAST_CYC; // RULE_12

         always_ff @(posedge ref_clk) begin
            if (srst) begin
               trip_cnt_reg  <= FILT_RESET;
               block_cnt_reg <= FILT_RESET;
            end else if (eval_tick) begin
               trip_cnt_reg  <= !raw_trip[g] ? FILT_RESET :
                  (trip_cnt_reg < need) ? trip_cnt_reg + 4'h1
                                        : trip_cnt_reg;
               block_cnt_reg <= !raw_block[g] ? FILT_RESET :
                  (block_cnt_reg < need) ? block_cnt_reg + 4'h1
                                         : block_cnt_reg;
            end
         end

         assign qual_trip[g]  = raw_trip[g] && (trip_cnt_reg >= need)
                                && active_w[g];
         assign qual_block[g] = raw_block[g] && (block_cnt_reg >= need)
                                && active_w[g];
      end
   endgenerate

   // ----------------------------------------------------------------
   // divisional combination
   // ----------------------------------------------------------------
   logic [1:0] trip_votes;
   always_comb begin
      trip_votes = 2'h0;
      for (int i = 0; i < N; i++)
         trip_votes = trip_votes + {1'b0, qual_trip[i]};
   end

   // coincident: two of the channels; one bypassed still leaves two
   wire logic coinc_trip = (trip_votes >= 2'h2); // RULE_17
   wire logic any_trip   = |qual_trip;
   // run mode suppresses all startup-range trips
   wire logic div_next   = !run_mode &&
                           (noncoinc ? any_trip : coinc_trip); // RULE_01 RULE_05
   wire logic [N-1:0] chan_trip_next =
      run_mode ? '0 : qual_trip; // RULE_01
   wire logic block_next = |qual_block;
   // permissive stays high unless a non-bypassed channel warns
   wire logic warn_next  = !(|(raw_warn & active_w));
   // boron permissive: any one in-service channel sees power low
   wire logic boron_next = |(boron_w & active_w); // RULE_10
   wire logic inop_next  = |inop_w; // RULE_08

   // ----------------------------------------------------------------
   // output registers, updated once per evaluation
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         div_scram_trip             <= 1'b0;
         chan_scram_trip            <= '0;
         rod_block                  <= 1'b1;
         withdraw_permissive        <= 1'b0;
         boron_injection_permissive <= 1'b0;
         inop_alarm                 <= 1'b0;
         chan_inop                  <= '0;
         coinc_alarm                <= 1'b0;
      end else if (eval_tick) begin // RULE_19
         div_scram_trip             <= div_next;
         chan_scram_trip            <= chan_trip_next;
         rod_block                  <= block_next;
         withdraw_permissive        <= warn_next;
         boron_injection_permissive <= boron_next;
         inop_alarm                 <= inop_next;
         chan_inop                  <= inop_w;
         coinc_alarm                <= coinc_warn;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence s_tick_run;
      eval_tick && run_mode;
   endsequence

   // evaluation outside run, where startup-range trips count
   sequence s_tick_live;
      eval_tick && !run_mode;
   endsequence

   a_run_no_trip: assert property (@(posedge ref_clk) disable iff (srst)
      s_tick_run |=> !div_scram_trip) // RULE_01
      else $error("divisional trip asserted in run");

   a_noncoinc_one: assert property (@(posedge ref_clk) disable iff (srst)
      eval_tick && noncoinc && any_trip |=> div_scram_trip) // RULE_02
      else $error("single channel did not trip in non-coincident mode");

   a_run_coinc: assert property (@(posedge ref_clk) disable iff (srst)
      run_mode |-> !noncoinc) // RULE_03
      else $error("non-coincident mode active in run");

   a_coinc_alarm: assert property (@(posedge ref_clk) disable iff (srst)
      (s_tick_run and (|noncoinc_s)) |=> coinc_alarm) // RULE_04
      else $error("coincidence alarm missing in run");

   a_coinc_vote: assert property (@(posedge ref_clk) disable iff (srst)
      eval_tick && !run_mode && !noncoinc && (trip_votes < 2'h2)
      |=> !div_scram_trip) // RULE_05
      else $error("coincident trip with fewer than two votes");

   a_inop_alarm: assert property (@(posedge ref_clk) disable iff (srst)
      eval_tick && (|inop_w) |=> inop_alarm && (chan_inop != '0)) // RULE_08
      else $error("inoperative alarm missing");

   a_bypass_drop: assert property (@(posedge ref_clk) disable iff (srst)
      eval_tick && (bypass_s != '0)
      |=> ((chan_scram_trip & $past(bypass_s)) == '0)) // RULE_13
      else $error("bypassed channel contributes a trip");

   a_block_hold: assert property (@(posedge ref_clk) disable iff (srst)
      eval_tick && (|qual_block) |=> rod_block) // RULE_15
      else $error("rod block missing");

   a_tick_space: assert property (@(posedge ref_clk) disable iff (srst)
      eval_tick |=> !eval_tick [*2]) // RULE_19
      else $error("evaluation ticks too close");

   // run zeroes the per-channel trips as well as the divisional one
   a_run_chan_zero: assert property (@(posedge ref_clk) disable iff (srst)
      s_tick_run |=> (chan_scram_trip == '0)) // RULE_01
      else $error("channel trip reported in run");

   // two qualified votes outside run must reach the division
   a_coinc_two: assert property (@(posedge ref_clk) disable iff (srst)
      (s_tick_live and (!noncoinc && (trip_votes >= 2'h2)))
      |=> div_scram_trip) // RULE_05
      else $error("coincident trip missing with two votes");

   a_coinc_clear: assert property (@(posedge ref_clk) disable iff (srst)
      eval_tick && !coinc_warn |=> !coinc_alarm) // RULE_04
      else $error("coincidence alarm without cause");

   a_chan_inop: assert property (@(posedge ref_clk) disable iff (srst)
      eval_tick |=> (chan_inop == $past(inop_w))) // RULE_07
      else $error("channel inoperative flags wrong");

   // permissive follows the warning both ways, or rods stall for nothing
   a_warn_drop: assert property (@(posedge ref_clk) disable iff (srst)
      eval_tick && (|(raw_warn & active_w))
      |=> !withdraw_permissive) // RULE_09
      else $error("withdrawal still permitted on short period");

   a_permit_hold: assert property (@(posedge ref_clk) disable iff (srst)
      eval_tick && !(|(raw_warn & active_w))
      |=> withdraw_permissive) // RULE_09
      else $error("withdrawal blocked without warning");

   // boron permissive tracks the in-service low-power channels
   a_boron_on: assert property (@(posedge ref_clk) disable iff (srst)
      eval_tick && (|(boron_w & active_w))
      |=> boron_injection_permissive) // RULE_10
      else $error("boron permissive missing");

   a_boron_off: assert property (@(posedge ref_clk) disable iff (srst)
      eval_tick && !(|(boron_w & active_w))
      |=> !boron_injection_permissive) // RULE_10
      else $error("boron permissive without cause");

   a_block_clear: assert property (@(posedge ref_clk) disable iff (srst)
      eval_tick && !(|qual_block)
      |=> !rod_block) // RULE_15
      else $error("rod block without cause");

   // between ticks the outputs must not move
   a_out_hold: assert property (@(posedge ref_clk) disable iff (srst)
      !eval_tick |=> $stable(div_scram_trip) && $stable(rod_block)
      && $stable(withdraw_permissive)) // RULE_19
      else $error("output changed between evaluations");

endmodule : srt_trip_logic

`default_nettype wire

// file: testbench/srt_rps_model.sv
// downstream protection model that seals in the divisional trip
`timescale 1ns/1ps
`default_nettype none

module srt_rps_model (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic srst,
   // divisional trip from the block
   input  wire logic div_scram_trip,
   // sealed-in trip state
   output var  logic rps_tripped
);
   // ---------------------------------------------------------------
   // seal-in
   // ---------------------------------------------------------------
   // a trip holds until reset, so a short trip pulse is never lost
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         rps_tripped <= 1'b0;
      end else if (div_scram_trip) begin
         rps_tripped <= 1'b1;
      end
   end
endmodule : srt_rps_model

`default_nettype wire

// file: testbench/startup_range_trip_logic_tb.sv
// self-checking bench for the startup-range trip logic
`timescale 1ns/1ps
`default_nettype none

module startup_range_trip_logic_tb
   import srt_pkg::*;
;
   logic        ref_clk = 1'b0;
   logic        srst;
   logic [1:0]  mode_sel;
   logic [2:0]  noncoinc_sel, chan_operate, interlock_closed, selftest_fail;
   logic [2:0]  excite_low, elec_fail, chan_bypass, chan_scram_trip, chan_inop;
   logic [47:0] flux, period_s, count_rate;
   logic [15:0] flux_hi_trip, flux_hi_block, flux_lo_block, period_trip;
   logic [15:0] period_block, period_warn, boron_flux_level, low_rate_level;
   logic        div_scram_trip, rod_block, withdraw_permissive;
   logic        boron_injection_permissive, inop_alarm, coinc_alarm;
   logic        rps_tripped;
   int          n_errors = 0;
   int          samples_checked = 0;
   int          cycles = 0;
   int          i;

   srt_trip_logic uut (.ref_clk(ref_clk), .srst(srst), .mode_sel(mode_sel),
      .noncoinc_sel(noncoinc_sel), .flux(flux), .period_s(period_s),
      .count_rate(count_rate), .flux_hi_trip(flux_hi_trip),
      .flux_hi_block(flux_hi_block), .flux_lo_block(flux_lo_block),
      .period_trip(period_trip), .period_block(period_block),
      .period_warn(period_warn), .boron_flux_level(boron_flux_level),
      .low_rate_level(low_rate_level), .chan_operate(chan_operate),
      .interlock_closed(interlock_closed), .selftest_fail(selftest_fail),
      .excite_low(excite_low), .elec_fail(elec_fail),
      .chan_bypass(chan_bypass), .div_scram_trip(div_scram_trip),
      .chan_scram_trip(chan_scram_trip), .rod_block(rod_block),
      .withdraw_permissive(withdraw_permissive),
      .boron_injection_permissive(boron_injection_permissive),
      .inop_alarm(inop_alarm), .chan_inop(chan_inop),
      .coinc_alarm(coinc_alarm));

   srt_rps_model rps (.ref_clk(ref_clk), .srst(srst),
      .div_scram_trip(div_scram_trip), .rps_tripped(rps_tripped));

   // 125 MHz clock
   always #4 ref_clk = ~ref_clk;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // outputs only move on evaluation ticks, so waits are whole ticks
   task automatic settle(input int n);
      repeat (n * EVAL_CYC) @(negedge ref_clk);
   endtask : settle

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // quiet plant: startup, mid-range flux, infinite period, fast rate
   task automatic restore();
      mode_sel = 2'h2;
      noncoinc_sel = 3'h0;
      flux = {3{16'h0064}};
      period_s = 48'h0;
      count_rate = {3{16'h03E8}};
      flux_hi_trip = 16'h03E8;
      flux_hi_block = 16'h0384;
      flux_lo_block = 16'h000A;
      period_trip = 16'h0014;
      period_block = 16'h001E;
      period_warn = 16'h0028;
      boron_flux_level = 16'h00C8;
      low_rate_level = 16'h0032;
      {chan_operate, interlock_closed} = 6'h3F;
      {selftest_fail, excite_low, elec_fail, chan_bypass} = 12'h000;
   endtask : restore

   task automatic clean();
      restore();
      settle(3);
   endtask : clean

   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : finish_test

   // hang guard, about twice the planned run
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 25000) begin
         n_errors++;
         finish_test();
      end
   end

   // ---------------------------------------------------------------
   // test sequence
   // ---------------------------------------------------------------
   initial begin
      srst = 1'b1;
      restore();
      repeat (8) @(negedge ref_clk);
      chk(rod_block, 1'b1);
      chk(div_scram_trip, 1'b0);
      srst = 1'b0;
      settle(3);
      chk(div_scram_trip, 1'b0);
      chk(rod_block, 1'b0);
      chk(withdraw_permissive, 1'b1);
      chk(boron_injection_permissive, 1'b1);
      chk(inop_alarm, 1'b0);
      chk(coinc_alarm, 1'b0);
      // single high channel, non-coincident then coincident
      noncoinc_sel = 3'h7;
      flux[15:0] = 16'h07D0;
      settle(3);
      chk(chan_scram_trip, 3'h1);
      chk(div_scram_trip, 1'b1);
      chk(rod_block, 1'b1);
      chk(rps_tripped, 1'b1);
      noncoinc_sel = 3'h0;
      settle(3);
      chk(div_scram_trip, 1'b0);
      flux[31:16] = 16'h07D0;
      settle(3);
      chk(div_scram_trip, 1'b1);
      flux_hi_trip = 16'h0FA0;
      settle(3);
      chk(div_scram_trip, 1'b0);
      // run mode suppresses trips and raises the coincidence alarm
      flux_hi_trip = 16'h03E8;
      noncoinc_sel = 3'h4;
      mode_sel = 2'h3;
      settle(3);
      chk(chan_scram_trip, 3'h0);
      chk(div_scram_trip, 1'b0);
      chk(coinc_alarm, 1'b1);
      mode_sel = 2'h2;
      settle(3);
      chk(div_scram_trip, 1'b1);
      chk(coinc_alarm, 1'b0);
      mode_sel = 2'h1;
      settle(3);
      chk(div_scram_trip, 1'b1);
      mode_sel = 2'h0;
      settle(3);
      chk(chan_scram_trip, 3'h3);
      // bypassed channel drops out
      clean();
      noncoinc_sel = 3'h7;
      chan_bypass = 3'h1;
      flux[15:0] = 16'h07D0;
      settle(3);
      chk(div_scram_trip, 1'b0);
      chk(rod_block, 1'b0);
      flux[31:16] = 16'h07D0;
      settle(3);
      chk(div_scram_trip, 1'b1);
      // short periods in coincident mode
      clean();
      period_s = {16'h000F, 16'h000F, 16'h0000};
      settle(3);
      chk(div_scram_trip, 1'b1);
      chk(chan_scram_trip, 3'h6);
      chk(rod_block, 1'b1);
      chk(withdraw_permissive, 1'b0);
      period_s = {16'h0023, 32'h0};
      settle(3);
      chk(withdraw_permissive, 1'b0);
      chk(rod_block, 1'b0);
      chk(div_scram_trip, 1'b0);
      period_s = {16'hFFFB, 16'hFF9C, 16'h0000};
      settle(3);
      chk(withdraw_permissive, 1'b1);
      chk(rod_block, 1'b0);
      // low flux block, boron permissive, electronic failure
      clean();
      flux = {16'h01F4, 16'h01F4, 16'h0005};
      settle(3);
      chk(rod_block, 1'b1);
      chk(boron_injection_permissive, 1'b1);
      flux[15:0] = 16'h01F4;
      settle(3);
      chk(boron_injection_permissive, 1'b0);
      chk(rod_block, 1'b0);
      elec_fail = 3'h4;
      settle(3);
      chk(rod_block, 1'b1);
      // each inoperative cause on channel 1
      for (i = 0; i < 4; i++) begin
         clean();
         noncoinc_sel = 3'h7;
         chan_operate = (i == 0) ? 3'h5 : 3'h7;
         interlock_closed = (i == 1) ? 3'h5 : 3'h7;
         selftest_fail = (i == 2) ? 3'h2 : 3'h0;
         excite_low = (i == 3) ? 3'h2 : 3'h0;
         settle(3);
         chk(chan_inop, 3'h2);
         chk(inop_alarm, 1'b1);
         chk(div_scram_trip, 1'b1);
      end
      // low count rate qualifies slowly
      clean();
      noncoinc_sel = 3'h7;
      count_rate[15:0] = 16'h000A;
      flux[15:0] = 16'h07D0;
      settle(3);
      chk(div_scram_trip, 1'b0);
      settle(8);
      chk(div_scram_trip, 1'b1);
      finish_test();
   end
endmodule : startup_range_trip_logic_tb

`default_nettype wire
